/* rtl/hq_pkg.sv */
// shared constants and types for the quad transceiver host port
package hq_pkg;
  localparam int HQ_NCHAN = 4;
  localparam int HQ_AW = 6;
  localparam int HQ_DW = 8;
  localparam int HQ_SER_AW = 5;
  localparam int HQ_CMD_RD = 0;
  localparam int HQ_CMD_ADDR = 1;
  localparam int HQ_CMD_BURST = 7;
  localparam int HQ_SDO_BIT = 7;
  localparam logic [2:0] HQ_BIT_LAST = 3'h7;
  localparam logic [2:0] HQ_BIT_RST = 3'h0;
  localparam logic [HQ_AW-1:0] HQ_ADDR_RST = 6'h00;
  localparam logic [7:0] HQ_OE_NONE = 8'h00;
  localparam logic [7:0] HQ_OE_ALL = 8'hff;
  localparam logic HQ_CS_N_RST = 1'b1;

  typedef enum logic [1:0] {
    HQ_MUX = 2'b00,
    HQ_NONMUX = 2'b01,
    HQ_SER = 2'b10,
    HQ_TEST = 2'b11
  } hq_mode_t;

  typedef enum logic [1:0] {
    HQ_S_CMD = 2'b00,
    HQ_S_WR = 2'b01,
    HQ_S_RD = 2'b10,
    HQ_S_DONE = 2'b11
  } hq_ser_t;

  typedef struct packed {
    logic [1:0] kind;
    logic [1:0] chan;
    logic style;
    logic in_edge;
    logic out_edge;
    logic cs_n;
    logic rd;
    logic wr;
    logic ale;
    logic [4:0] addr;
    logic [7:0] data;
  } hq_pins_t;

  typedef struct packed {
    logic vld;
    logic [1:0] chan;
    logic [HQ_AW-1:0] addr;
    logic [HQ_DW-1:0] data;
  } hq_wr_t;

  typedef struct packed {
    hq_pins_t s1;
    hq_pins_t s2;
    hq_pins_t s3;
    logic [HQ_AW-1:0] lat_addr;
    logic [HQ_DW-1:0] wdat;
    hq_ser_t ser;
    logic [2:0] bcnt;
    logic [7:0] sh;
    logic [HQ_SER_AW-1:0] saddr;
    logic burst;
    logic [7:0] bus_o;
    logic [7:0] bus_oe;
    logic int_oe;
    hq_wr_t wr;
  } hq_state_t;
endpackage

/* rtl/hq_host_port.sv */
// host access port: parallel and serial register access, interrupt pin
`timescale 1ns/1ps
`default_nettype none
module hq_host_port
  import hq_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic bus_kind_sel_lo,
  input wire logic bus_kind_sel_hi,
  input wire logic channel_sel_lo,
  input wire logic channel_sel_hi,
  input wire logic strobe_style_sel,
  input wire logic in_edge_sel,
  input wire logic out_edge_sel,
  input wire logic chip_sel_n,
  input wire logic read_or_data_strobe,
  input wire logic write_or_dir,
  input wire logic addr_latch_or_top_addr,
  input wire logic [4:0] direct_addr_pins,
  input wire logic [7:0] shared_bus_pins_i,
  output logic [7:0] shared_bus_pins_o,
  output logic [7:0] shared_bus_pins_oe,
  input wire logic [HQ_NCHAN-1:0] chan_int_req,
  output logic int_n_o,
  output logic int_n_oe,
  output hq_wr_t wr_evt_o
);
  logic [1:0] rst_sync_r;
  logic rst_n;
  hq_state_t q_r;
  hq_state_t q_nxt;
  hq_pins_t pins;
  hq_pins_t p;
  hq_pins_t o;
  hq_mode_t mode;
  logic [HQ_DW-1:0] bank [HQ_NCHAN*(2**HQ_AW)];
  logic we;
  logic [HQ_AW+1:0] widx;
  logic [HQ_DW-1:0] wd;
  logic cs;
  logic mux;
  logic par;
  logic rd_act;
  logic par_wr_end;
  logic [HQ_AW-1:0] paddr;
  logic [HQ_DW-1:0] rdat_p;
  logic [HQ_DW-1:0] rdat_s;
  logic sdo_bit;
  logic sin_e;
  logic sout_e;
  logic [7:0] sh_new;

  // reset enters asynchronously, leaves through two flops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  always_comb begin
    pins.kind = {bus_kind_sel_hi, bus_kind_sel_lo};
    pins.chan = {channel_sel_hi, channel_sel_lo};
    pins.style = strobe_style_sel;
    pins.in_edge = in_edge_sel;
    pins.out_edge = out_edge_sel;
    pins.cs_n = chip_sel_n;
    pins.rd = read_or_data_strobe;
    pins.wr = write_or_dir;
    pins.ale = addr_latch_or_top_addr;
    pins.addr = direct_addr_pins;
    pins.data = shared_bus_pins_i;
  end

  // s1 is only a synchroniser stage; logic reads s2 and s3
  assign p = q_r.s2;
  assign o = q_r.s3;
  assign mode = hq_mode_t'(p.kind);
  assign cs = !p.cs_n;
  assign mux = (mode == HQ_MUX);
  assign par = !p.kind[1];

  // write strobe active for one sampled pin set
  function automatic logic f_wact(hq_pins_t x, logic m);
    logic ds;
    ds = m ? x.rd : !x.rd;
    if (x.style) begin
      f_wact = !x.cs_n && ds && !x.wr;
    end else begin
      f_wact = !x.cs_n && !x.wr;
    end
  endfunction

  function automatic logic f_ract(hq_pins_t x, logic m);
    logic ds;
    ds = m ? x.rd : !x.rd;
    if (x.style) begin
      f_ract = !x.cs_n && ds && x.wr;
    end else begin
      f_ract = !x.cs_n && !x.rd;
    end
  endfunction

  assign rd_act = par && f_ract(p, mux);
  // a write lands when its strobe (or chip select) ends
  assign par_wr_end = par && f_wact(o, mux) && !f_wact(p, mux);
  // nonmuxed address is latch pin over the direct pins
  assign paddr = mux ? q_r.lat_addr : {p.ale, p.addr};
  assign rdat_p = bank[{p.chan, paddr}];
  // serial commands carry five address bits, so they reach 0..31 only
  assign rdat_s = bank[{p.chan, 1'b0, q_r.saddr}];
  assign sdo_bit = rdat_s[q_r.bcnt];
  assign sin_e = p.in_edge ? (!p.rd && o.rd) : (p.rd && !o.rd);
  assign sout_e = p.out_edge ? (p.rd && !o.rd) : (!p.rd && o.rd);
  assign sh_new = {p.wr, q_r.sh[7:1]};

  always_comb begin
    q_nxt = q_r;
    we = 1'b0;
    widx = '0;
    wd = '0;
    q_nxt.s1 = pins;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    q_nxt.bus_oe = HQ_OE_NONE;
    // address travels on the shared pins ahead of the data
    if (mux && p.ale && !o.ale) begin
      q_nxt.lat_addr = p.data[HQ_AW-1:0];
    end
    if (f_wact(p, mux)) begin
      q_nxt.wdat = p.data;
    end
    if (rd_act) begin
      q_nxt.bus_o = rdat_p;
      q_nxt.bus_oe = HQ_OE_ALL;
    end
    if (par_wr_end) begin
      we = 1'b1;
      widx = {p.chan, paddr};
      wd = q_r.wdat;
    end
    // serial: chip select high ends the transfer and floats the output
    if (mode != HQ_SER || !cs) begin
      q_nxt.ser = HQ_S_CMD;
      q_nxt.bcnt = HQ_BIT_RST;
      q_nxt.sh = '0;
    end else begin
      q_nxt.bus_oe[HQ_SDO_BIT] = q_r.bus_oe[HQ_SDO_BIT];
      if (sin_e) begin
        case (q_r.ser)
          HQ_S_CMD: begin
            q_nxt.sh = sh_new;
            q_nxt.bcnt = 3'(q_r.bcnt + 3'h1);
            if (q_r.bcnt == HQ_BIT_LAST) begin
              q_nxt.saddr = sh_new[HQ_CMD_ADDR+:HQ_SER_AW];
              q_nxt.burst = sh_new[HQ_CMD_BURST];
              q_nxt.ser = sh_new[HQ_CMD_RD] ? HQ_S_RD : HQ_S_WR;
            end
          end
          HQ_S_WR: begin
            q_nxt.sh = sh_new;
            q_nxt.bcnt = 3'(q_r.bcnt + 3'h1);
            if (q_r.bcnt == HQ_BIT_LAST) begin
              we = 1'b1;
              widx = {p.chan, 1'b0, q_r.saddr};
              wd = sh_new;
              if (q_r.burst) begin
                q_nxt.saddr = 5'(q_r.saddr + 5'h01);
              end else begin
                q_nxt.ser = HQ_S_DONE;
              end
            end
          end
          default: begin
          end
        endcase
      end
      // last driven bit is held until the next update or deselect
      if (sout_e && q_r.ser == HQ_S_RD) begin
        q_nxt.bus_o[HQ_SDO_BIT] = sdo_bit;
        q_nxt.bus_oe[HQ_SDO_BIT] = 1'b1;
        q_nxt.bcnt = 3'(q_r.bcnt + 3'h1);
        if (q_r.bcnt == HQ_BIT_LAST) begin
          if (q_r.burst) begin
            q_nxt.saddr = 5'(q_r.saddr + 5'h01);
          end else begin
            q_nxt.ser = HQ_S_DONE;
          end
        end
      end
    end
    if (mode == HQ_TEST) begin
      q_nxt.bus_oe = HQ_OE_NONE;
    end
    q_nxt.int_oe = (mode != HQ_TEST) && (|chan_int_req);
    q_nxt.wr.vld = we;
    q_nxt.wr.chan = widx[HQ_AW+1:HQ_AW];
    q_nxt.wr.addr = widx[HQ_AW-1:0];
    q_nxt.wr.data = wd;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '0;
      // pin stages wake up deselected: an all-zero pin set would look
      // like an active strobe whose end then fires a phantom write
      q_r.s1.cs_n <= HQ_CS_N_RST;
      q_r.s2.cs_n <= HQ_CS_N_RST;
      q_r.s3.cs_n <= HQ_CS_N_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // register banks have no reset; software initialises them
  always_ff @(posedge clock) begin
    if (we) begin
      bank[widx] <= wd;
    end
  end

  // open drain: only ever pulls low
  assign int_n_o = 1'b0;
  assign int_n_oe = q_r.int_oe;
  assign shared_bus_pins_o = q_r.bus_o;
  assign shared_bus_pins_oe = q_r.bus_oe;
  assign wr_evt_o = q_r.wr;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_ale_rise;
    mux && p.ale && !o.ale;
  endsequence

  sequence s_cmd_bit;
    mode == HQ_SER && cs && sin_e && q_r.ser == HQ_S_CMD;
  endsequence

  sequence s_deselect;
    !cs ##1 !cs;
  endsequence

  chk_int_assert: assert property (
    (mode != HQ_TEST && |chan_int_req) |=> int_n_oe)
    else $error("interrupt not driven");

  chk_int_release: assert property (
    !(|chan_int_req) |=> !int_n_oe)
    else $error("interrupt held without cause");

  chk_test_hiz: assert property (
    mode == HQ_TEST |=> shared_bus_pins_oe == 8'h00 && !int_n_oe)
    else $error("drive in test mode");

  chk_cs_block: assert property (
    s_deselect |=> !wr_evt_o.vld && shared_bus_pins_oe == 8'h00)
    else $error("access while deselected");

  chk_mux_latch: assert property (
    s_ale_rise |=> q_r.lat_addr == $past(p.data[5:0]))
    else $error("muxed address not latched");

  chk_nonmux_addr: assert property (
    (mode == HQ_NONMUX && par_wr_end) |=>
      wr_evt_o.vld && wr_evt_o.addr == $past(paddr) &&
      wr_evt_o.chan == $past(p.chan))
    else $error("nonmuxed write address wrong");

  chk_par_read: assert property (
    rd_act |=> shared_bus_pins_oe == 8'hff &&
      shared_bus_pins_o == $past(rdat_p))
    else $error("parallel read data wrong");

  chk_ser_pins: assert property (
    mode == HQ_SER |=> shared_bus_pins_oe[6:0] == 7'h00)
    else $error("serial mode drives data pins");

  chk_ser_sample: assert property (
    s_cmd_bit |=> q_r.sh[7] == $past(p.wr))
    else $error("serial input not sampled");

  chk_ser_cmd: assert property (
    (s_cmd_bit ##0 q_r.bcnt == 3'h7) |=>
      (q_r.ser == HQ_S_RD) == $past(q_r.sh[1]) &&
      q_r.burst == $past(p.wr))
    else $error("command byte decoded wrong");

  chk_ser_out: assert property (
    (mode == HQ_SER && cs && sout_e && q_r.ser == HQ_S_RD) |=>
      shared_bus_pins_oe[7] && shared_bus_pins_o[7] == $past(sdo_bit))
    else $error("serial output not updated");
endmodule
`default_nettype wire

/* tb/hq_host_model.sv */
// host side wire model: shared bus and open-drain interrupt line
`timescale 1ns/1ps
`default_nettype none
module hq_host_model (
  input wire logic clock,
  input wire logic [7:0] host_d,
  input wire logic host_oe,
  input wire logic [7:0] dev_d,
  input wire logic [7:0] dev_oe,
  input wire logic int_oe,
  input wire logic int_d,
  output logic [7:0] bus,
  output logic int_line
);
  logic [7:0] last_r = 8'h00;
  // a released bus toggles so stale data can never pass for a read
  always @(posedge clock) begin
    last_r <= bus;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      bus[i] = dev_oe[i] ? dev_d[i] : (host_oe ? host_d[i] : ~last_r[i]);
    end
  end
  // pull-up on the interrupt line
  assign int_line = int_oe ? int_d : 1'b1;
endmodule
`default_nettype wire

/* tb/hq_host_port_tb.sv */
// self-checking bench for the host access port
`timescale 1ns/1ps
`default_nettype none
module hq_host_port_tb;
  import hq_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] kind = 2'h1;
  logic [1:0] chan = 2'h0;
  logic style = 1'b0;
  logic ie = 1'b0;
  logic oes = 1'b0;
  logic cs_n = 1'b1;
  logic csoff = 1'b0;
  logic rds = 1'b1;
  logic wrd = 1'b1;
  logic ale = 1'b0;
  logic ho = 1'b0;
  logic [4:0] da = 5'h00;
  logic [7:0] hb = 8'h00;
  logic [3:0] ireq = 4'h0;
  logic [7:0] bus, dev_o, dev_oe, got, got_oe;
  logic [15:0] gs;
  logic int_oe, int_n, int_line;
  hq_wr_t evt, ev;
  int errors = 0;
  int n_compared = 0;
  int nev = 0;
  int n0 = 0;

  always #5 clock = ~clock;
  // write pulses last one cycle, so they are caught here, not polled
  always @(posedge clock) begin
    if (evt.vld === 1'b1) begin
      ev <= evt;
      nev <= nev + 1;
    end
  end

  hq_host_port dut (
    .clock(clock), .resetn(resetn),
    .bus_kind_sel_lo(kind[0]), .bus_kind_sel_hi(kind[1]),
    .channel_sel_lo(chan[0]), .channel_sel_hi(chan[1]),
    .strobe_style_sel(style), .in_edge_sel(ie), .out_edge_sel(oes),
    .chip_sel_n(cs_n), .read_or_data_strobe(rds), .write_or_dir(wrd),
    .addr_latch_or_top_addr(ale), .direct_addr_pins(da),
    .shared_bus_pins_i(bus), .shared_bus_pins_o(dev_o),
    .shared_bus_pins_oe(dev_oe), .chan_int_req(ireq),
    .int_n_o(int_n), .int_n_oe(int_oe), .wr_evt_o(evt)
  );
  hq_host_model host (
    .clock(clock), .host_d(hb), .host_oe(ho), .dev_d(dev_o),
    .dev_oe(dev_oe), .int_oe(int_oe), .int_d(int_n), .bus(bus),
    .int_line(int_line)
  );

  task test_done;
    if (errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task acc(input logic r, input logic [5:0] a, input logic [7:0] d);
    logic act;
    act = style & ~kind[0];
    if (kind == 2'h0) begin
      ale = 1'b0;
      da = 5'h00;
      hb = {2'h0, a};
      ho = 1'b1;
      cyc(3);
      ale = 1'b1;
      cyc(4);
      ale = 1'b0;
      cyc(2);
    end else begin
      da = a[4:0];
      ale = a[5];
    end
    hb = d;
    ho = ~r;
    cs_n = csoff;
    if (style) begin
      wrd = r;
      rds = act;
    end else if (r) rds = 1'b0;
    else wrd = 1'b0;
    cyc(6);
    got = bus;
    got_oe = dev_oe;
    rds = ~act;
    wrd = 1'b1;
    cs_n = 1'b1;
    ho = 1'b0;
    cyc(6);
  endtask

  task ev_chk(input logic [1:0] c, input logic [5:0] a, input logic [7:0] d);
    for (int k = 0; k < 20 && nev == n0; k++) cyc(1);
    cmp(nev, n0 + 1);
    cmp(32'(ev), 32'({1'b1, c, a, d}));
    n0 = nev;
  endtask

  // serial clock idles low; data moves mid-way through the low half
  // output is sampled late in the half period after its update edge
  task ser(input logic [7:0] cmd, input logic [15:0] d, input int nb);
    cs_n = 1'b0;
    cyc(4);
    for (int i = 0; i < 8 * nb + 8; i++) begin
      cyc(2);
      wrd = (i < 8) ? cmd[i] : d[i-8];
      cyc(2);
      if (i >= 8 && !oes) gs[i-8] = bus[HQ_SDO_BIT];
      rds = 1'b1;
      cyc(4);
      if (i >= 8 && oes) gs[i-8] = bus[HQ_SDO_BIT];
      rds = 1'b0;
    end
    cyc(4);
    cs_n = 1'b1;
    cyc(8);
  endtask

  initial begin
    repeat (12) @(posedge clock);
    #1;
    resetn = 1'b1;
    cyc(8);
    for (int m = 0; m < 4; m++) begin
      kind = {1'b0, m[0]};
      style = m[1];
      rds = ~(style & ~kind[0]);
      cyc(6);
      chan = 2'h1;
      acc(1'b0, 6'h25, 8'h5a ^ m[7:0]);
      ev_chk(2'h1, 6'h25, 8'h5a ^ m[7:0]);
      chan = 2'h2;
      acc(1'b0, 6'h25, 8'ha5);
      ev_chk(2'h2, 6'h25, 8'ha5);
      chan = 2'h1;
      csoff = 1'b1;
      acc(1'b0, 6'h25, 8'h00);
      cmp(nev, n0);
      csoff = 1'b0;
      acc(1'b1, 6'h25, 8'h00);
      cmp(32'(got), 32'(8'h5a ^ m[7:0]));
      chan = 2'h2;
      acc(1'b1, 6'h25, 8'h00);
      cmp(32'(got), 32'h000000a5);
    end
    kind = 2'h2;
    style = 1'b0;
    rds = 1'b0;
    chan = 2'h3;
    cyc(6);
    for (int e = 0; e < 2; e++) begin
      ie = e[0];
      ser({2'h0, 5'h13 + e[4:0], 1'b0}, {8'h00, 8'hc3 ^ e[7:0]}, 1);
      ev_chk(2'h3, {1'b0, 5'h13 + e[4:0]}, 8'hc3 ^ e[7:0]);
    end
    ie = 1'b0;
    cyc(4);
    ser({2'h0, 5'h13, 1'b1}, 16'h0000, 1);
    cmp(32'(gs[7:0]), 32'h000000c3);
    oes = 1'b1;
    cyc(4);
    ser({2'h2, 5'h13, 1'b1}, 16'h0000, 2);
    cmp(32'(gs), 32'h0000c2c3);
    oes = 1'b0;
    kind = 2'h3;
    ireq = 4'h4;
    rds = 1'b1;
    cyc(6);
    cmp(32'(int_line), 32'h00000001);
    acc(1'b1, 6'h25, 8'h00);
    cmp(32'(got_oe), 32'h00000000);
    kind = 2'h1;
    cyc(6);
    cmp(32'(int_line), 32'h00000000);
    ireq = 4'h0;
    cyc(3);
    cmp(32'(int_line), 32'h00000001);
    test_done;
  end
endmodule
`default_nettype wire
